// ---- verilog/sync_serial_slave_sleep.sv ----
// Synchronous slave serial port that keeps shifting while the core is halted.
// Assumes config bits come from core-clock logic; the link clock comes from the master.
//
// What this block does
// R1: Software selects slave by clocked mode 1, clock source master 0, port enable 1.
// R2: Transmitter only while both receive enables are clear, receiver otherwise.
// R3: Slave transmit moves holding word to shift register like master, external clock.
// R4: With two words written, first shifts at once, second waits, flag stays clear.
// R5: After first word shifts out, waiting word is staged and empty flag sets in the same edge.
// R6: Transmit flag with peripheral and transmit enables wakes core; global enters service.
// R7: Transmit shifting advances only on master clock edges; master supplies them.
// R8: Software sets ninth bit enables and bit before writing the low byte.
// R9: In slave receive either receive enable selects continuous reception; single enable alone acts as continuous.
// R10: Word clocked in during halt reaches data register and wakes core if enabled.
// R11: Receive flag sets per word; ninth bit read before low byte.
// R12: Clearing continuous receive or port enable clears overrun; port disable empties holding register and receive buffer.
// R13: Only synchronous slave mode keeps shifting through a halt.
// R14: Transmit and receive shift registers run on the external clock.
// R15: Software empties the receive buffer before halting to receive.
// R16: During halt the receive flag sets on a complete word and wakes core.
// R17: In halted transmit, finished word pulls pending byte and sets flag, waking core.
// R18: A write to the holding register clears the transmit empty flag.
// R19: Software fills shift and holding registers and enables interrupts before halting.
// R20: Software disables analog function on clock and data pins.
// R21: After wake execution resumes; service entered only with global enable.
// R22: Data changes on leading edge, valid at trailing edge, one bit per clock.
// R23: Buffer holds two; third word flags overrun; nothing accepted until cleared.
// R24: Data pin driven only as slave transmitter with transmit enabled.
`default_nettype none

module sync_serial_slave_sleep
    import sync_serial_slave_pkg::*;
(
    // Core clock and reset
    input  wire logic               i_core_clk,
    input  wire logic               i_arst_n,
    // Link clock from the external master, leading edge is rising
    input  wire logic               i_slave_clk,
    // Mode configuration
    input  wire logic               i_sync_mode,
    input  wire logic               i_clock_source_master,
    input  wire logic               i_port_enable,
    input  wire logic               i_single_rx_enable,
    input  wire logic               i_continuous_rx_enable,
    input  wire logic               i_tx_enable,
    input  wire logic               i_ninth_bit_tx_enable,
    input  wire logic               i_ninth_bit_rx_enable,
    // Interrupt enables and core halt state
    input  wire logic               i_tx_irq_enable,
    input  wire logic               i_rx_irq_enable,
    input  wire logic               i_peripheral_irq_enable,
    input  wire logic               i_global_irq_enable,
    input  wire logic               i_core_halt,
    // Transmit holding register write
    input  wire logic               i_tx_write,
    input  wire logic [WORD_W-1:0]  i_tx_data,
    input  wire logic               i_tx_ninth_bit,
    // Receive data register read
    input  wire logic               i_rx_read,
    output logic      [WORD_W-1:0]  o_rx_data_reg,
    output logic                    o_rx_ninth_bit,
    // Status
    output logic                    o_tx_buffer_empty_flag,
    output logic                    o_rx_ready_flag,
    output logic                    o_overrun_flag,
    output logic                    o_wake,
    output logic                    o_service,
    // Serial data pin
    input  wire logic               i_serial_data_in,
    output logic                    o_serial_data_out,
    output logic                    o_serial_data_oe
);

    // Core domain state
    typedef struct packed {
        logic [CHAR_W-1:0] hold_word;
        logic              hold_full;
        logic [CHAR_W-1:0] stage_word;
        logic              stage_nine;
        logic              req_tgl;
        logic              ack_s1;
        logic              ack_s2;
        logic              done_s1;
        logic              done_s2;
        logic              rxt_s1;
        logic              rxt_s2;
        logic              rxt_s3;
        logic [PTR_W-1:0]  wr_ptr;
        logic [PTR_W-1:0]  rd_ptr;
        logic [1:0]        count;
        logic              rx_ready;
        logic              overrun;
        logic              link_tx_en;
        logic              link_rx_en;
        logic              oe;
        logic              wake;
        logic              service;
    } core_s;

    // Link domain, leading-edge side
    typedef struct packed {
        logic [1:0]        en_s1;
        logic [1:0]        en_s2;
        logic              nine_s1;
        logic              nine_s2;
        tx_state_e         state;
        logic [CHAR_W-1:0] shift;
        logic [CNT_W-1:0]  idx;
        logic [CNT_W-1:0]  last;
        logic              ack_tgl;
    } rise_s;

    // Link domain, trailing-edge side
    typedef struct packed {
        logic [CHAR_W-1:0] rx_shift;
        logic [CNT_W-1:0]  rx_cnt;
        logic [CHAR_W-1:0] rx_word;
        logic              rx_tgl;
        logic              done_tgl;
    } fall_s;

    core_s c_ff;
    core_s nxt_c;
    rise_s r_ff;
    rise_s nxt_r;
    fall_s f_ff;
    fall_s nxt_f;

    logic [CHAR_W-1:0] rd_char;
    logic              slave;
    logic              rx_mode;
    logic              link_free;
    logic              xfer;
    logic              rx_evt;
    logic              push;
    logic              pop;
    logic              tx_irq;
    logic              rx_irq;
    logic              tx_done;
    logic [CHAR_W-1:0] rx_in;
    logic [CNT_W-1:0]  rx_last;

    // Core side: holding register, receive buffer control, flags and wake
    always_comb begin
        nxt_c = c_ff;
        slave   = i_sync_mode && !i_clock_source_master && i_port_enable;
        rx_mode = i_single_rx_enable || i_continuous_rx_enable; // R2 R9
        // Two-stage synchronisers for link events
        nxt_c.ack_s1  = r_ff.ack_tgl;
        nxt_c.ack_s2  = c_ff.ack_s1;
        nxt_c.done_s1 = f_ff.done_tgl;
        nxt_c.done_s2 = c_ff.done_s1;
        nxt_c.rxt_s1  = f_ff.rx_tgl;
        nxt_c.rxt_s2  = c_ff.rxt_s1;
        nxt_c.rxt_s3  = c_ff.rxt_s2;
        // Link is free once it took the last word and finished shifting it
        link_free = (c_ff.req_tgl == c_ff.ack_s2) && (c_ff.done_s2 == c_ff.ack_s2);
        xfer   = c_ff.hold_full && link_free && c_ff.link_tx_en; // R3 R4 R5 R17
        rx_evt = c_ff.rxt_s2 != c_ff.rxt_s3;
        push   = rx_evt && c_ff.link_rx_en && !c_ff.overrun
                 && (c_ff.count != RX_FULL_CNT); // R10 R16 R23
        pop    = i_rx_read && (c_ff.count != RX_EMPTY);
        // Holding to shift transfer; the empty flag rises in the same edge
        if (xfer) begin
            nxt_c.stage_word = c_ff.hold_word;
            nxt_c.stage_nine = i_ninth_bit_tx_enable;
            nxt_c.req_tgl    = ~c_ff.req_tgl;
            nxt_c.hold_full  = 1'b0; // R5
        end
        // A write when full and not draining is dropped
        if (i_tx_write && (!c_ff.hold_full || xfer)) begin
            nxt_c.hold_word = {i_tx_ninth_bit, i_tx_data}; // R8
            nxt_c.hold_full = 1'b1; // R18
        end
        if (push) begin
            nxt_c.wr_ptr = c_ff.wr_ptr + PTR_STEP;
        end
        if (pop) begin
            nxt_c.rd_ptr = c_ff.rd_ptr + PTR_STEP;
        end
        if (push && !pop) begin
            nxt_c.count = c_ff.count + CNT_STEP;
        end else if (pop && !push) begin
            nxt_c.count = c_ff.count - CNT_STEP;
        end
        nxt_c.rx_ready = c_ff.count != RX_EMPTY; // R11
        // Overrun: a level clear, but a new third word still wins
        if (!i_continuous_rx_enable || !i_port_enable) begin
            nxt_c.overrun = 1'b0; // R12
        end
        if (rx_evt && c_ff.link_rx_en && (c_ff.count == RX_FULL_CNT)) begin
            nxt_c.overrun = 1'b1; // R23
        end
        // Port disable empties the holding register and the receive buffer
        if (!i_port_enable) begin
            nxt_c.hold_full = 1'b0; // R12
            nxt_c.wr_ptr    = '0;
            nxt_c.rd_ptr    = '0;
            nxt_c.count     = RX_EMPTY;
            nxt_c.rx_ready  = 1'b0;
        end
        // Only slave mode runs the link, so nothing shifts in halt otherwise
        nxt_c.link_tx_en = slave && !rx_mode && i_tx_enable; // R13 R2
        nxt_c.link_rx_en = slave && rx_mode; // R13 R9
        nxt_c.oe         = slave && !rx_mode && i_tx_enable; // R24
        // Wake needs the peripheral enable; the vector also needs the global one
        tx_irq = !c_ff.hold_full && i_tx_irq_enable && i_peripheral_irq_enable;
        rx_irq = c_ff.rx_ready && i_rx_irq_enable && i_peripheral_irq_enable;
        nxt_c.wake    = i_core_halt && (tx_irq || rx_irq); // R6 R10 R16 R17
        nxt_c.service = i_global_irq_enable && (tx_irq || rx_irq); // R6 R21
    end

    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            c_ff <= '0;
        end else begin
            c_ff <= nxt_c;
        end
    end

    // Receive characters, top entry read out through a register
    rx_char_store u_store (
        .i_core_clk (i_core_clk),
        .i_arst_n   (i_arst_n),
        .i_wr_en    (push),
        .i_wr_addr  (c_ff.wr_ptr),
        .i_wr_data  (f_ff.rx_word),
        .i_rd_addr  (c_ff.rd_ptr),
        .o_rd_data  (rd_char)
    );

    // Link leading edge: load the staged word or put the next bit out.
    // The staged word and request stay still while the link reports busy.
    always_comb begin
        nxt_r = r_ff;
        nxt_r.en_s1   = {c_ff.link_rx_en, c_ff.link_tx_en};
        nxt_r.en_s2   = r_ff.en_s1;
        nxt_r.nine_s1 = i_ninth_bit_rx_enable;
        nxt_r.nine_s2 = r_ff.nine_s1;
        tx_done = f_ff.done_tgl == r_ff.ack_tgl;
        if (!r_ff.en_s2[0]) begin
            nxt_r.state = TX_IDLE;
        end else if ((r_ff.state == TX_IDLE) || tx_done) begin
            if (c_ff.req_tgl != r_ff.ack_tgl) begin
                nxt_r.shift   = c_ff.stage_word; // R3 R14
                nxt_r.idx     = BIT_ZERO;
                nxt_r.last    = c_ff.stage_nine ? LAST_BIT_9 : LAST_BIT_8;
                nxt_r.ack_tgl = ~r_ff.ack_tgl;
                nxt_r.state   = TX_SHIFT;
            end else begin
                nxt_r.state = TX_IDLE;
            end
        end else begin
            nxt_r.shift = {1'b0, r_ff.shift[CHAR_W-1:1]}; // R7 R22
            nxt_r.idx   = r_ff.idx + BIT_STEP;
        end
    end

    always_ff @(posedge i_slave_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            r_ff <= '0;
        end else begin
            r_ff <= nxt_r;
        end
    end

    // Link trailing edge: sample received bits and mark the end of a sent word
    always_comb begin
        nxt_f = f_ff;
        rx_in   = {i_serial_data_in, f_ff.rx_shift[CHAR_W-1:1]}; // R22
        rx_last = r_ff.nine_s2 ? LAST_BIT_9 : LAST_BIT_8;
        if (r_ff.en_s2[1]) begin
            nxt_f.rx_shift = rx_in; // R14
            nxt_f.rx_cnt   = f_ff.rx_cnt + BIT_STEP;
            if (f_ff.rx_cnt == rx_last) begin
                nxt_f.rx_word = r_ff.nine_s2 ? rx_in : {1'b0, rx_in[CHAR_W-1:1]};
                nxt_f.rx_tgl  = ~f_ff.rx_tgl; // R11 R16
                nxt_f.rx_cnt  = BIT_ZERO;
            end
        end else begin
            nxt_f.rx_cnt = BIT_ZERO;
        end
        // Word complete after the trailing edge of its last bit
        if (!r_ff.en_s2[0]) begin
            nxt_f.done_tgl = r_ff.ack_tgl;
        end else if ((r_ff.state == TX_SHIFT) && (r_ff.idx == r_ff.last)
                     && (f_ff.done_tgl != r_ff.ack_tgl)) begin
            nxt_f.done_tgl = ~f_ff.done_tgl; // R5 R17
        end
    end

    always_ff @(negedge i_slave_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            f_ff <= '0;
        end else begin
            f_ff <= nxt_f;
        end
    end

    // Outputs
    assign o_rx_data_reg          = rd_char[WORD_W-1:0];
    assign o_rx_ninth_bit         = rd_char[CHAR_W-1];
    assign o_tx_buffer_empty_flag = !c_ff.hold_full;
    assign o_rx_ready_flag        = c_ff.rx_ready;
    assign o_overrun_flag         = c_ff.overrun;
    assign o_wake                 = c_ff.wake;
    assign o_service              = c_ff.service;
    assign o_serial_data_out      = r_ff.shift[0];
    assign o_serial_data_oe       = c_ff.oe;

    // Checks in the core domain
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_arst_n);

    sequence s_xfer;
        xfer && !i_tx_write;
    endsequence

    sequence s_flag_up;
        o_tx_buffer_empty_flag && (c_ff.req_tgl != $past(c_ff.req_tgl));
    endsequence

    tx_write_clear_a: assert property ( // R18
        i_tx_write && i_port_enable |=> !o_tx_buffer_empty_flag)
        else $error("write did not clear empty flag");

    tx_xfer_flag_a: assert property (s_xfer ##1 i_port_enable |-> s_flag_up) // R5
        else $error("transfer did not raise empty flag with request");

    tx_wait_hold_a: assert property ( // R4
        c_ff.hold_full && !link_free && !xfer
        |=> !o_tx_buffer_empty_flag || !$past(i_port_enable))
        else $error("waiting word set flag early");

    rx_flag_rise_a: assert property ( // R16
        push && !pop && c_ff.count == RX_EMPTY && i_port_enable
        ##1 i_port_enable |=> o_rx_ready_flag)
        else $error("receive flag late");

    overrun_set_a: assert property ( // R23
        rx_evt && c_ff.link_rx_en && c_ff.count == RX_FULL_CNT |=> o_overrun_flag)
        else $error("third word did not flag overrun");

    overrun_hold_a: assert property ( // R23
        c_ff.overrun && !pop && i_port_enable |=> c_ff.count == $past(c_ff.count))
        else $error("word accepted during overrun");

    overrun_clear_a: assert property ( // R12
        !i_continuous_rx_enable && !rx_evt |=> !o_overrun_flag)
        else $error("overrun not cleared");

    wake_tx_a: assert property ( // R6
        i_core_halt && !c_ff.hold_full && i_tx_irq_enable && i_peripheral_irq_enable |=> o_wake)
        else $error("transmit flag did not wake");

    service_gate_a: assert property (o_service |-> $past(i_global_irq_enable)) // R21
        else $error("service without global enable");

    data_oe_a: assert property ( // R24
        o_serial_data_oe |-> $past(!i_single_rx_enable && !i_continuous_rx_enable && i_tx_enable))
        else $error("data pin driven outside transmit");

endmodule

`default_nettype wire

// ---- include/sync_serial_slave_pkg.sv ----
// Shared constants for the synchronous slave serial port.
// Assumes a core clock domain and a link clock domain fed by the external master.
`default_nettype none

package sync_serial_slave_pkg;

    // Character geometry
    localparam int          WORD_W      = 8;
    localparam int          CHAR_W      = 9;
    localparam int          CNT_W       = 4;
    localparam logic [3:0]  LAST_BIT_8  = 4'h7;
    localparam logic [3:0]  LAST_BIT_9  = 4'h8;
    localparam logic [3:0]  BIT_STEP    = 4'h1;
    localparam logic [3:0]  BIT_ZERO    = 4'h0;

    // Receive buffer holds two characters
    localparam int          RX_DEPTH    = 2;
    localparam int          PTR_W       = 1;
    localparam logic [1:0]  RX_FULL_CNT = 2'h2;
    localparam logic [1:0]  RX_EMPTY    = 2'h0;
    localparam logic [1:0]  CNT_STEP    = 2'h1;
    localparam logic [0:0]  PTR_STEP    = 1'h1;

    // Reset values
    localparam logic [8:0]  CHAR_RESET  = 9'h000;

    // Link transmit sequencer, Gray coded
    typedef enum logic [0:0] {
        TX_IDLE  = 1'h0,
        TX_SHIFT = 1'h1
    } tx_state_e;

endpackage

`default_nettype wire

// ---- verilog/rx_char_store.sv ----
// Two-entry receive character store with a registered read port.
// Assumes the writer never writes a full store; read data lag the address by one clock.
`default_nettype none

module rx_char_store
    import sync_serial_slave_pkg::*;
(
    // Clock and reset
    input  wire logic               i_core_clk,
    input  wire logic               i_arst_n,
    // Write port
    input  wire logic               i_wr_en,
    input  wire logic [PTR_W-1:0]   i_wr_addr,
    input  wire logic [CHAR_W-1:0]  i_wr_data,
    // Read port
    input  wire logic [PTR_W-1:0]   i_rd_addr,
    output logic      [CHAR_W-1:0]  o_rd_data
);

    logic [CHAR_W-1:0] entry_ff [RX_DEPTH];

    // One storage word per entry
    genvar gi;
    generate
        for (gi = 0; gi < RX_DEPTH; gi++) begin : g_entry
            always_ff @(posedge i_core_clk or negedge i_arst_n) begin
                if (!i_arst_n) begin
                    entry_ff[gi] <= CHAR_RESET;
                end else if (i_wr_en && (i_wr_addr == PTR_W'(gi))) begin
                    entry_ff[gi] <= i_wr_data;
                end
            end
        end
    endgenerate

    // Registered read keeps the output free of address glitches
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_rd_data <= CHAR_RESET;
        end else begin
            o_rd_data <= entry_ff[i_rd_addr];
        end
    end

endmodule

`default_nettype wire

// ---- tb/serial_master_model.sv ----
// Behavioural synchronous master standing on the link side of the slave port.
// Assumes the bench resolves the data pin from the slave's output enable.
`default_nettype none

module serial_master_model (
    // Link clock and data toward the slave
    output logic        o_link_clk,
    output logic        o_data,
    // Resolved data pin
    input  wire logic   i_pin
);
    timeunit 1ns;
    timeprecision 100ps;

    // Clock rests low between frames so the slave sees no stray edges
    initial begin
        o_link_clk = 1'b0;
        o_data     = 1'b1;
    end

    // One frame, LSB first; exactly n clocks, then the clock stops
    task automatic xfer(input logic [8:0] mosi, input int n, output logic [8:0] miso);
        miso = 9'h000;
        for (int i = 0; i < n; i++) begin
            o_link_clk = 1'b1;
            o_data     = mosi[i];
            #62.5;
            o_link_clk = 1'b0;
            miso[i]    = i_pin;
            #62.5;
        end
        // A released line shows the opposite level, never a held copy
        o_data = ~o_data;
    endtask
endmodule

`default_nettype wire

// ---- tb/test_sync_serial_slave_sleep.sv ----
// Self-checking bench for the synchronous slave port with core halt.
// Assumes the master model drives the link clock and pin on the far side.
`default_nettype none

module test_sync_serial_slave_sleep
    import sync_serial_slave_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    // Core side stimulus
    logic              clk, arst_n, sync, csm, port_en, srx, crx, tx_enable, tx9, rx9;
    logic              txie, rxie, peripheral_irq_enable, global_irq_enable, halt, tx_write, tx_ninth, rx_read;
    logic [WORD_W-1:0] tx_data;
    // Observed outputs and link wires
    logic [WORD_W-1:0] rx_data;
    logic              rx_ninth, txe, rxf, ovr, wake, service, dout, doe, m_data, lclk;
    logic [8:0]        got;
    int                errors, n_checks;
    wire logic         pin = doe ? dout : m_data;

    sync_serial_slave_sleep DUT (
        .i_core_clk(clk), .i_arst_n(arst_n), .i_slave_clk(lclk),
        .i_sync_mode(sync), .i_clock_source_master(csm), .i_port_enable(port_en),
        .i_single_rx_enable(srx), .i_continuous_rx_enable(crx), .i_tx_enable(tx_enable),
        .i_ninth_bit_tx_enable(tx9), .i_ninth_bit_rx_enable(rx9),
        .i_tx_irq_enable(txie), .i_rx_irq_enable(rxie), .i_peripheral_irq_enable(peripheral_irq_enable),
        .i_global_irq_enable(global_irq_enable), .i_core_halt(halt), .i_tx_write(tx_write),
        .i_tx_data(tx_data), .i_tx_ninth_bit(tx_ninth), .i_rx_read(rx_read),
        .o_rx_data_reg(rx_data), .o_rx_ninth_bit(rx_ninth), .o_tx_buffer_empty_flag(txe),
        .o_rx_ready_flag(rxf), .o_overrun_flag(ovr), .o_wake(wake), .o_service(service),
        .i_serial_data_in(pin), .o_serial_data_out(dout), .o_serial_data_oe(doe)
    );

    serial_master_model M (.o_link_clk(lclk), .o_data(m_data), .i_pin(pin));

    // Core clock, 25 ns period
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic check(input string nm, input logic [8:0] seen, input logic [8:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic chk1(input string nm, input logic seen, input logic exp);
        check(nm, {8'h00, seen}, {8'h00, exp});
    endtask

    task automatic summarize;
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    // Bounded wait for a status level; running out ends the run
    task automatic wait_hi(input int sel);
        logic v;
        for (int i = 0; i < 60; i++) begin
            @(negedge clk);
            case (sel)
                0: v = txe;
                1: v = rxf;
                2: v = ovr;
                default: v = service;
            endcase
            if (v === 1'b1) begin
                return;
            end
        end
        errors++;
        $display("[ERR] wait %0d expected 1 seen 0", sel);
        summarize();
    endtask

    // Holding write; the strobe stays up so back-to-back writes need no gap
    task automatic wr(input logic [8:0] w);
        tx_write = 1'b1;
        tx_data  = w[7:0];
        tx_ninth = w[8];
        @(negedge clk);
    endtask

    // One link frame, then an idle gap so the next word can be staged
    task automatic link(input logic [8:0] w, input int n);
        M.xfer(w, n, got);
        cyc(8);
    endtask

    // Check the top entry, then pop it
    task automatic rd(input logic [8:0] exp);
        check("rx word", {rx_ninth, rx_data}, exp);
        rx_read = 1'b1;
        @(negedge clk);
        rx_read = 1'b0;
        cyc(3);
    endtask

    initial begin
        {srx, crx, tx9, rx9, txie, rxie, peripheral_irq_enable, global_irq_enable, halt, tx_write, tx_ninth, rx_read} = '0;
        tx_data  = 8'h00;
        errors   = 0;
        n_checks = 0;
        arst_n   = 1'b0;
        sync     = 1'b1;
        csm      = 1'b0;
        port_en  = 1'b1;
        tx_enable     = 1'b1;
        // Count rising edges so the start-up edge of the clock cannot shorten reset
        repeat (3) @(posedge clk);
        @(negedge clk);
        arst_n = 1'b1;
        cyc(2);
        chk1("tx empty", txe, 1'b1);
        chk1("rx ready", rxf, 1'b0);
        chk1("overrun", ovr, 1'b0);
        chk1("pin drive", doe, 1'b1);
        link(9'h000, 2);
        cyc(4);
        $display("test reset done");

        // Two words written, then the core halts with the clock stopped
        txie = 1'b1;
        peripheral_irq_enable = 1'b1;
        wr(9'h0a5);
        wr(9'h03c);
        tx_write = 1'b0;
        halt     = 1'b1;
        chk1("tx empty", txe, 1'b0);
        cyc(20);
        chk1("tx empty", txe, 1'b0);
        chk1("wake", wake, 1'b0);
        link(9'h000, 8);
        check("tx word", got, 9'h0a5);
        wait_hi(0);
        chk1("wake", wake, 1'b1);
        chk1("service", service, 1'b0);
        global_irq_enable = 1'b1;
        wait_hi(3);
        link(9'h000, 8);
        check("tx word", got, 9'h03c);
        tx9 = 1'b1;
        wr(9'h15a);
        tx_write = 1'b0;
        chk1("tx empty", txe, 1'b0);
        wait_hi(0);
        link(9'h000, 9);
        check("tx word", got, 9'h15a);
        $display("test transmit done");

        // Receiver through single enable only, nine-bit words
        {txie, global_irq_enable} = 2'b00;
        rx9  = 1'b1;
        srx  = 1'b1;
        cyc(2);
        chk1("pin drive", doe, 1'b0);
        // One clock only: a second would already be sampled as a received bit
        link(9'h000, 1);
        cyc(4);
        rxie = 1'b1;
        chk1("rx ready", rxf, 1'b0);
        link(9'h196, 9);
        wait_hi(1);
        chk1("wake", wake, 1'b1);
        chk1("service", service, 1'b0);
        rd(9'h196);
        chk1("rx ready", rxf, 1'b0);
        $display("test receive done");

        // Third word overruns; later words are refused until cleared
        crx = 1'b1;
        srx = 1'b0;
        cyc(4);
        link(9'h011, 9);
        link(9'h122, 9);
        link(9'h033, 9);
        wait_hi(2);
        link(9'h144, 9);
        rd(9'h011);
        // Room in the buffer now, but overrun still refuses the word
        link(9'h155, 9);
        chk1("overrun", ovr, 1'b1);
        srx = 1'b1;
        crx = 1'b0;
        cyc(4);
        chk1("overrun", ovr, 1'b0);
        rd(9'h122);
        chk1("rx ready", rxf, 1'b0);
        link(9'h0ff, 9);
        wait_hi(1);
        port_en = 1'b0;
        cyc(4);
        chk1("rx ready", rxf, 1'b0);
        $display("test overrun done");
        summarize();
    end
endmodule

`default_nettype wire
